// ---- logic/lsp_pkg.sv ----
/*
  Shared constants and types for the LCD staging register port.
  Assumes a 16-bit processor bus on the same clock as the port.
*/
package lsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry and decode.
  localparam int LSP_ADDR_W = 16;
  localparam int LSP_DATA_W = 16;
  localparam logic [15:0] LSP_PORT_OFFSET = 16'h0010;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the port word.
  localparam int LSP_BIT_HALF_A = 0;
  localparam int LSP_BIT_HALF_B = 1;
  localparam int LSP_BIT_CMD_DATA = 6;
  localparam int LSP_BIT_DIR = 7;
  localparam int LSP_DATA_LSB = 8;
  localparam int LSP_DATA_MSB = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic LSP_RST_SEL = 1'b0;
  localparam logic LSP_RST_CMD_DATA = 1'b0;
  localparam logic LSP_RST_DIR = 1'b0;
  localparam logic [7:0] LSP_RST_DATA = 8'h00;
  localparam logic [15:0] LSP_RST_RDATA = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser depth.
  localparam int LSP_SYNC_STAGES = 3;

  // Latched state of the module interface.
  typedef struct packed {
    logic [7:0] data;
    logic dir;
    logic cmd_data_sel;
    logic half_b;
    logic half_a;
  } lsp_ctrl_t;

  // Reverse a byte: port bit 8 carries module data bit 7.
  function automatic logic [7:0] lsp_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : lsp_rev8

endpackage : lsp_pkg

// ---- logic/lsp_pin_sync.sv ----
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes inputs arrive asynchronously to mclk.
*/
`timescale 1ns/1ps
module lsp_pin_sync
  import lsp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Asynchronous input and filtered result.
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_q
);

  // Refuse a width the logic cannot serve.
  if (WIDTH < 1 || LSP_SYNC_STAGES != 3) begin : g_chk
    $error("lsp_pin_sync needs WIDTH of at least one and three stages.");
  end

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next values: the output follows only where stages two and three agree.
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // Registers.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end

  assign pin_q = out_q;

endmodule : lsp_pin_sync

// ---- logic/lsp_port.sv ----
/*
  Registered 16-bit staging port between the processor memory bus and a
  character LCD module; software sequences the module strobes.
  Assumes bus strobes are synchronous to mclk and last one cycle each;
  the map strap and the module data lines are asynchronous pins.
*/
// Functional notes
// - One 16-bit latched port at bus speed.
// - Bit 0 drives panel half A select.
// - Bit 1 drives panel half B select.
// - Bit 6 drives command/data select.
// - Bit 7 drives direction, one means read.
// - Bits 8..15 carry byte reversed, tristate by direction.
// - Decoded at region three plus 0x10, strap-gated.
`timescale 1ns/1ps
module lsp_port
  import lsp_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Processor bus side.
  input wire logic chip_sel_region_three_n,
  input wire logic [LSP_ADDR_W-1:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [LSP_DATA_W-1:0] bus_wdata,
  output logic [LSP_DATA_W-1:0] bus_rdata_q,
  output logic bus_ack_q,
  // Board map strap enabling the port.
  input wire logic map_enable_pin,
  // LCD module side.
  output logic panel_half_a_sel_q,
  output logic panel_half_b_sel_q,
  output logic cmd_data_sel_q,
  output logic lcd_dir_q,
  output logic [7:0] lcd_data_out_q,
  output logic lcd_data_oe_q,
  input wire logic [7:0] lcd_data_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the strap and the module data lines.

  logic map_en_s;
  logic [7:0] lcd_data_s;

  // Strap passes four flops before it gates the decode.
  lsp_pin_sync #(
    .WIDTH(1)
  ) u_map_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_in(map_enable_pin),
    .pin_q(map_en_s)
  );

  // Module data lines are sampled the same way before a read returns them.
  lsp_pin_sync #(
    .WIDTH(8)
  ) u_data_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_in(lcd_data_in),
    .pin_q(lcd_data_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic hit;
  logic wr_hit;
  logic rd_hit;

  // Only the one word at the port offset answers, and only when strapped in.
  assign hit = !chip_sel_region_three_n && map_en_s &&
               (bus_addr == LSP_PORT_OFFSET[LSP_ADDR_W-1:0]);
  assign wr_hit = hit && bus_wr;
  assign rd_hit = hit && bus_rd && !bus_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Latched port state.

  lsp_ctrl_t ctrl_q, ctrl_d;
  logic [LSP_DATA_W-1:0] rdata_d;
  logic ack_d;
  logic oe_d;
  logic [7:0] dout_d;

  // A write takes the whole word in one bus cycle, so the bus never waits on
  // the module. Between writes every field simply holds. The host does the
  // strobe sequencing; this logic imposes no order on the accesses.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_hit) begin
      ctrl_d.half_a = bus_wdata[LSP_BIT_HALF_A];
      ctrl_d.half_b = bus_wdata[LSP_BIT_HALF_B];
      ctrl_d.cmd_data_sel = bus_wdata[LSP_BIT_CMD_DATA];
      ctrl_d.dir = bus_wdata[LSP_BIT_DIR];
      ctrl_d.data = bus_wdata[LSP_DATA_MSB:LSP_DATA_LSB];
    end
  end

  // Outputs to the module are registered from the next state so they stay
  // glitch free; the data bus is only driven while direction says write.
  always_comb begin
    oe_d = !ctrl_d.dir;
    dout_d = lsp_rev8(ctrl_d.data);
  end

  // Read-back: control bits from the latch, unused bits zero, the data byte
  // from the module pins when reading, else the latched byte.
  always_comb begin
    rdata_d = bus_rdata_q;
    ack_d = hit && (bus_wr || bus_rd);
    if (rd_hit) begin
      rdata_d = '0;
      rdata_d[LSP_BIT_HALF_A] = ctrl_q.half_a;
      rdata_d[LSP_BIT_HALF_B] = ctrl_q.half_b;
      rdata_d[LSP_BIT_CMD_DATA] = ctrl_q.cmd_data_sel;
      rdata_d[LSP_BIT_DIR] = ctrl_q.dir;
      if (ctrl_q.dir) begin
        rdata_d[LSP_DATA_MSB:LSP_DATA_LSB] = lsp_rev8(lcd_data_s);
      end else begin
        rdata_d[LSP_DATA_MSB:LSP_DATA_LSB] = ctrl_q.data;
      end
    end
  end

  // Registers; both panel selects come up idle.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= '{data: LSP_RST_DATA, dir: LSP_RST_DIR,
                  cmd_data_sel: LSP_RST_CMD_DATA,
                  half_b: LSP_RST_SEL, half_a: LSP_RST_SEL};
      bus_rdata_q <= LSP_RST_RDATA;
      bus_ack_q <= 1'b0;
      lcd_data_oe_q <= !LSP_RST_DIR;
      lcd_data_out_q <= LSP_RST_DATA;
    end else begin
      ctrl_q <= ctrl_d;
      bus_rdata_q <= rdata_d;
      bus_ack_q <= ack_d;
      lcd_data_oe_q <= oe_d;
      lcd_data_out_q <= dout_d;
    end
  end

  // Module controls straight from the latch.
  assign panel_half_a_sel_q = ctrl_q.half_a;
  assign panel_half_b_sel_q = ctrl_q.half_b;
  assign cmd_data_sel_q = ctrl_q.cmd_data_sel;
  assign lcd_dir_q = ctrl_q.dir;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // A write completes in one cycle and is answered the next.
  property p_write_fast;
    wr_hit |=> bus_ack_q && (lcd_dir_q == $past(bus_wdata[LSP_BIT_DIR]));
  endproperty
  a_write_fast: assert property (p_write_fast)
    else $error("Port write not latched and acknowledged in one cycle.");

  property p_half_a;
    wr_hit |=> panel_half_a_sel_q == $past(bus_wdata[LSP_BIT_HALF_A]);
  endproperty
  a_half_a: assert property (p_half_a)
    else $error("Half A select does not follow bit 0.");

  property p_half_b;
    wr_hit |=> panel_half_b_sel_q == $past(bus_wdata[LSP_BIT_HALF_B]);
  endproperty
  a_half_b: assert property (p_half_b)
    else $error("Half B select does not follow bit 1.");

  property p_cmd_data;
    wr_hit |=> cmd_data_sel_q == $past(bus_wdata[LSP_BIT_CMD_DATA]);
  endproperty
  a_cmd_data: assert property (p_cmd_data)
    else $error("Command/data select does not follow bit 6.");

  property p_dir_oe;
    lcd_data_oe_q == !lcd_dir_q;
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("Data drive not opposite to direction.");

  property p_data_rev;
    wr_hit |=> lcd_data_out_q == lsp_rev8($past(bus_wdata[15:8]));
  endproperty
  a_data_rev: assert property (p_data_rev)
    else $error("Module data byte not bit reversed from port.");

  property p_decode;
    (bus_wr || bus_rd) && !hit |=> !bus_ack_q;
  endproperty
  a_decode: assert property (p_decode)
    else $error("Port answered an access it does not own.");

  property p_hold;
    !wr_hit |=> $stable(ctrl_q) && $stable(lcd_data_out_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Port values changed without a write.");

  property p_read_back;
    rd_hit |=> bus_rdata_q[LSP_BIT_DIR] == $past(lcd_dir_q) &&
               bus_rdata_q[5:2] == 4'h0 && bus_ack_q;
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("Port read returned wrong control bits.");

endmodule : lsp_port

// ---- tb/lsp_lcd_model.sv ----
/*
  Behavioural character LCD module for the staging port bench.
  Assumes the port drives selects, direction and data on mclk.
*/
`timescale 1ns/1ps
module lsp_lcd_model (
  // Clock.
  input wire logic mclk,
  // Pins from the port.
  input wire logic sel_a,
  input wire logic sel_b,
  input wire logic dir,
  input wire logic [7:0] dout,
  // Byte to return on reads, byte caught on writes.
  input wire logic [7:0] rd_byte,
  output logic [7:0] din,
  output logic [7:0] got
);
  logic sel_d;

  ////////////////////////////////////////////////////////////////////////////
  // Released lines move every cycle so stale values never pass.
  initial din = 8'h5A;
  always @(posedge mclk) begin
    sel_d <= sel_a | sel_b;
    if ((sel_a | sel_b) && dir) begin
      din <= rd_byte;
    end else begin
      din <= ~din;
    end
    // The module takes the byte when its select goes idle.
    if (sel_d && !(sel_a | sel_b) && !dir) begin
      got <= dout;
    end
  end
endmodule : lsp_lcd_model

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the LCD staging port.
  Assumes strobes are one-cycle pulses driven at the falling edge.
*/
`timescale 1ns/1ps
module tb_top
  import lsp_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cs_n = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic strap = 1'b1;
  logic [7:0] rd_byte = 8'h1E;
  logic [15:0] rdata;
  logic ack, sa, sb, cds, dir, oe;
  logic [7:0] dout, din, got;
  int err_total = 0;
  int checks = 0;

  // A 50 ns clock.
  always #25 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // Port and module model.
  lsp_port u_dut (.mclk(mclk), .reset(reset),
    .chip_sel_region_three_n(cs_n), .bus_addr(addr), .bus_wr(wr),
    .bus_rd(rd), .bus_wdata(wdata), .bus_rdata_q(rdata),
    .bus_ack_q(ack), .map_enable_pin(strap), .panel_half_a_sel_q(sa),
    .panel_half_b_sel_q(sb), .cmd_data_sel_q(cds), .lcd_dir_q(dir),
    .lcd_data_out_q(dout), .lcd_data_oe_q(oe), .lcd_data_in(din));
  lsp_lcd_model u_lcd (.mclk(mclk), .sel_a(sa), .sel_b(sb), .dir(dir),
    .dout(dout), .rd_byte(rd_byte), .din(din), .got(got));

  ////////////////////////////////////////////////////////////////////////////
  // Byte reversal worked out here, independent of the design.
  function automatic logic [7:0] flip(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      flip[i] = v[7 - i];
    end
  endfunction : flip

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Compares two words.
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Module pins expected from the last port word.
  task automatic pins(input logic [15:0] w);
    chk({3'b000, dout, dir, cds, oe, sb, sa},
      {3'b000, flip(w[15:8]), w[7], w[6], ~w[7], w[1], w[0]});
  endtask : pins

  // One bus access; the ack is awaited for at most three cycles.
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [15:0] d, input logic c, input logic ea,
    output logic [15:0] r);
    logic seen;
    seen = 1'b0;
    r = 16'h0000;
    @(negedge mclk);
    cs_n = c;
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    @(negedge mclk);
    wr = 1'b0;
    rd = 1'b0;
    for (int n = 0; n < 3 && !seen; n++) begin
      if (ack === 1'b1) begin
        seen = 1'b1;
        r = rdata;
      end else begin
        @(negedge mclk);
      end
    end
    cs_n = 1'b1;
    chk({15'h0000, seen}, {15'h0000, ea});
    if (ea && !seen) begin
      end_sim();
    end
  endtask : acc

  // Write transfer in exactly three accesses; the read-back of the idle
  // word comes after the transfer so no read sits inside a write sequence.
  task automatic wxfer(input logic [15:0] w, input logic [1:0] s);
    logic [15:0] r;
    acc(1'b1, LSP_PORT_OFFSET, w, 1'b0, 1'b1, r);
    pins(w);
    acc(1'b1, LSP_PORT_OFFSET, w | {14'h0000, s}, 1'b0, 1'b1, r);
    pins(w | {14'h0000, s});
    acc(1'b1, LSP_PORT_OFFSET, w, 1'b0, 1'b1, r);
    pins(w);
    repeat (2) @(negedge mclk);
    chk({8'h00, got}, {8'h00, flip(w[15:8])});
    acc(1'b0, LSP_PORT_OFFSET, 16'h0000, 1'b0, 1'b1, r);
    chk(r, w);
  endtask : wxfer

  // Read transfer in four accesses.
  task automatic rxfer(input logic [15:0] w, input logic [1:0] s);
    logic [15:0] r;
    acc(1'b1, LSP_PORT_OFFSET, w, 1'b0, 1'b1, r);
    pins(w);
    acc(1'b1, LSP_PORT_OFFSET, w | {14'h0000, s}, 1'b0, 1'b1, r);
    pins(w | {14'h0000, s});
    repeat (6) @(negedge mclk);
    acc(1'b0, LSP_PORT_OFFSET, 16'h0000, 1'b0, 1'b1, r);
    chk(r, {flip(rd_byte), w[7:6], 4'h0, s});
    acc(1'b1, LSP_PORT_OFFSET, w, 1'b0, 1'b1, r);
    pins(w);
  endtask : rxfer

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [15:0] r;
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    pins(16'h0000);
    repeat (6) @(negedge mclk);
    $display("reset test done");
    wxfer(16'hA540, 2'b01);
    wxfer(16'h3800, 2'b10);
    $display("write test done");
    rxfer(16'h00C0, 2'b01);
    // A new module byte, so a stale synchronised value cannot pass.
    rd_byte = 8'h2D;
    rxfer(16'h5A80, 2'b10);
    $display("read test done");
    acc(1'b1, 16'h0012, 16'hFFFF, 1'b0, 1'b0, r);
    acc(1'b1, LSP_PORT_OFFSET, 16'hFFFF, 1'b1, 1'b0, r);
    strap = 1'b0;
    repeat (6) @(negedge mclk);
    acc(1'b1, LSP_PORT_OFFSET, 16'hFFFF, 1'b0, 1'b0, r);
    pins(16'h5A80);
    $display("decode test done");
    end_sim();
  end
endmodule : tb_top
